// ===== design/acs_sequencer.sv
// conversion sequencing, control word and result port of a 10-bit converter
// assumes: host drives cs/wr/rd/clkin/data pins asynchronously to clk_sys;
// the analog core presents an offset-binary code on raw_code, same clock.
//
// Summary of operation
// - conversion takes 14, double 28 clocks
// - busy low 1.5 to 2.5 clocks after write
// - single completion within 19.5 clocks plus 70ns
// - double completion within 33.5 clocks plus 70ns
// - write or read falling edge clears interrupt
// - results presented as ten-bit twos complement
// - irq mode selects busy or interrupt behaviour
// - data lines bidirectional, write control, read result
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // host bus pins
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic clkin,
  input wire logic [DATA_W-1:0] data_port_lines_in,
  output logic [DATA_W-1:0] data_port_lines_out,
  output logic data_port_lines_oe,
  output logic status_n,
  // analog core
  input wire logic [DATA_W-1:0] raw_code,
  output logic sample_hold,
  output logic code_take,
  output logic linear_off
);

  // ===========================================================
  // pin synchronisers
  // ===========================================================
  acs_pins_s pins_raw;
  acs_pins_s pins_meta;
  acs_pins_s pins_sync;
  acs_pins_s pins_last;

  assign pins_raw = '{cs_n: cs_n, wr_n: wr_n, rd_n: rd_n, clkin: clkin,
                      data: data_port_lines_in};

  // two stages; only the second stage feeds any logic
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pins_meta <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, clkin: 1'b0, data: '0};
      pins_sync <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, clkin: 1'b0, data: '0};
    end else begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
    end
  end

  // previous synced value, for edge detection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pins_last <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, clkin: 1'b0, data: '0};
    end else begin
      pins_last <= pins_sync;
    end
  end

  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic clk_rise;
  logic clk_fall;
  logic wr_active;
  logic rd_active;

  // strobes count only while the chip is selected
  assign wr_active = ~pins_sync.wr_n & ~pins_sync.cs_n;
  assign rd_active = ~pins_sync.rd_n & ~pins_sync.cs_n;
  assign wr_fall = pins_last.wr_n & ~pins_sync.wr_n & ~pins_sync.cs_n;
  assign wr_rise = ~pins_last.wr_n & pins_sync.wr_n & ~pins_last.cs_n;
  assign rd_fall = pins_last.rd_n & ~pins_sync.rd_n & ~pins_sync.cs_n;
  assign rd_rise = ~pins_last.rd_n & pins_sync.rd_n & ~pins_last.cs_n;
  assign clk_rise = ~pins_last.clkin & pins_sync.clkin;
  assign clk_fall = pins_last.clkin & ~pins_sync.clkin;

  // ===========================================================
  // control word
  // ===========================================================
  logic [DATA_W-1:0] ctrl_hold;
  logic [DATA_W-1:0] ctrl;

  // data hold time after the strobe is short, so keep the last value seen
  // while the strobe was low and commit that on the rising edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_hold <= CTRL_RESET;
    end else if (wr_active) begin
      ctrl_hold <= pins_sync.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (wr_rise) begin
      ctrl <= ctrl_hold;
    end
  end

  logic irq_mode_bit;
  logic power_down_bit;
  logic dual_sample_bit;
  assign irq_mode_bit = ctrl[IRQ_MODE_POS];
  assign power_down_bit = ctrl[POWER_DOWN_POS];
  assign dual_sample_bit = ctrl[DUAL_SAMPLE_POS];

  assign linear_off = power_down_bit;

  // ===========================================================
  // conversion sequencer
  // ===========================================================
  acs_state_e state;
  logic [1:0] edge_cnt;
  logic [5:0] conv_cnt;
  logic dual_run;
  logic conv_done;
  logic start_req;

  // a write that leaves the part powered up starts a conversion
  assign start_req = wr_rise & ~ctrl_hold[POWER_DOWN_POS];

  assign conv_done = (state == ACS_CONVERT) && clk_rise &&
                     (conv_cnt == (dual_run ? DOUBLE_CLKS : SINGLE_CLKS) - 6'h01);

  // one clock domain, so converter timing is paced by sampled clkin edges;
  // this costs up to three system clocks of latency on every edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ACS_IDLE;
      edge_cnt <= 2'h0;
      conv_cnt <= 6'h00;
      dual_run <= 1'b0;
    end else if (start_req) begin
      // a new write restarts the sequence
      state <= ACS_ARM;
      edge_cnt <= 2'h0;
      conv_cnt <= 6'h00;
      dual_run <= ctrl_hold[DUAL_SAMPLE_POS];
    end else if (wr_rise) begin
      // power-down aborts conversion
      // the linear side is off, so a running conversion cannot finish
      state <= ACS_IDLE;
    end else begin
      unique case (state)
        ACS_IDLE: begin
          state <= ACS_IDLE;
        end
        ACS_ARM: begin
          if (clk_rise) begin
            edge_cnt <= edge_cnt + 2'h1;
            if (edge_cnt == START_EDGES - 2'h1) begin
              state <= ACS_WAIT_FALL;
            end
          end
        end
        ACS_WAIT_FALL: begin
          // busy falls half a clock after start edge
          if (clk_fall) begin
            state <= ACS_CONVERT;
          end
        end
        ACS_CONVERT: begin
          if (clk_rise) begin
            conv_cnt <= conv_cnt + 6'h01;
          end
          if (conv_done) begin
            state <= ACS_IDLE;
          end
        end
      endcase
    end
  end

  // sampler holds during the conversion phase
  assign sample_hold = (state == ACS_CONVERT);

  // first code taken at the midpoint of a double conversion, second at the end
  logic mid_done;
  assign mid_done = (state == ACS_CONVERT) && dual_run && clk_rise &&
                    (conv_cnt == SINGLE_CLKS - 6'h01);
  assign code_take = conv_done | mid_done;

  // ===========================================================
  // result registers
  // ===========================================================
  logic [DATA_W-1:0] result_a;
  logic [DATA_W-1:0] result_b;
  logic read_second;

  function automatic logic [DATA_W-1:0] to_twos(input logic [DATA_W-1:0] code);
    to_twos = {~code[DATA_W-1], code[DATA_W-2:0]};
  endfunction : to_twos

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      result_a <= '0;
      result_b <= '0;
    end else if (mid_done) begin
      result_a <= to_twos(raw_code);
    end else if (conv_done) begin
      if (dual_run) begin
        result_b <= to_twos(raw_code);
      end else begin
        result_a <= to_twos(raw_code);
      end
    end
  end

  // after a double conversion reads alternate first then second channel;
  // the toggle waits for the end of a read so the word stays put while read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      read_second <= 1'b0;
    end else if (conv_done) begin
      read_second <= 1'b0;
    end else if (rd_rise && dual_run) begin
      read_second <= ~read_second;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_port_lines_out <= '0;
      data_port_lines_oe <= 1'b0;
    end else begin
      data_port_lines_out <= read_second ? result_b : result_a;
      data_port_lines_oe <= rd_active;
    end
  end

  // ===========================================================
  // busy / interrupt output
  // ===========================================================
  logic int_flag;

  // strobe falling edge clears interrupt
  // completion sets the flag; set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      int_flag <= 1'b0;
    end else if (conv_done) begin
      int_flag <= 1'b1;
    end else if (wr_fall || rd_fall) begin
      int_flag <= 1'b0;
    end
  end

  // mode bit picks busy or interrupt
  // completion releases busy or raises interrupt
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_n <= 1'b1;
    end else if (irq_mode_bit) begin
      status_n <= ~(int_flag | conv_done);
    end else begin
      status_n <= ~((state == ACS_CONVERT) & ~conv_done);
    end
  end

endmodule : acs_sequencer

// ===== inc/acs_pkg.sv
// shared constants and types of the conversion sequencer
// assumes one 40 MHz system clock; all pin-side signals arrive asynchronously
package acs_pkg;

  // system clock period in picoseconds (40 MHz)
  localparam int unsigned CLK_PERIOD_PS = 25000;

  // data port width and control word layout
  localparam int unsigned DATA_W = 10;
  localparam int unsigned IRQ_MODE_POS = 9;
  localparam int unsigned POWER_DOWN_POS = 8;
  localparam int unsigned DUAL_SAMPLE_POS = 6;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // converter clock edges: busy drops on the falling edge after start edge two
  localparam logic [1:0] START_EDGES = 2'h2;
  // converter clocks per conversion, single and double
  localparam logic [5:0] SINGLE_CLKS = 6'h0e;
  localparam logic [5:0] DOUBLE_CLKS = 6'h1c;

  // interface clock period limits in ns, kept for reference; no check uses them
  localparam int unsigned CLKIN_MIN_NS = 125;
  localparam int unsigned CLKIN_MAX_NS = 500;

  // sequencer states
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_ARM,
    ACS_WAIT_FALL,
    ACS_CONVERT
  } acs_state_e;

  // synchronised pin group
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic clkin;
    logic [9:0] data;
  } acs_pins_s;

endpackage : acs_pkg

// ===== verification/acs_monitor.sv
// pin assertions of the conversion sequencer
// assumes the host model runs clkin at 8 clk_sys cycles a period
`timescale 1ns/1ps
module acs_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // pins
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic data_port_lines_oe,
  input wire logic status_n,
  input wire logic sample_hold,
  input wire logic code_take,
  input wire logic linear_off
);
  // ==========
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [8:0] run_len;
  // high time of the conversion phase, cleared while idle
  always_ff @(posedge clk_sys) begin
    if (reset || !sample_hold) run_len <= 9'h000;
    else run_len <= run_len + 9'h001;
  end
  sequence rd_start;
    $fell(rd_n) && !cs_n;
  endsequence
  chk_conv_length: assert property ($fell(sample_hold) |-> run_len >= 9'h068 && run_len <= 9'h0f0)
    else $error("conversion phase length wrong");
  chk_conv_ends: assert property ($rose(sample_hold) |-> ##[1:240] !sample_hold)
    else $error("conversion phase never ends");
  chk_take_pulse: assert property (code_take |=> !code_take)
    else $error("code take longer than one cycle");
  chk_take_in_conv: assert property (code_take |-> sample_hold || $past(sample_hold))
    else $error("code taken outside conversion");
  chk_power_quiet: assert property (linear_off |-> !sample_hold)
    else $error("conversion while powered down");
  chk_power_by_write: assert property ($changed(linear_off) |-> wr_n &&
    (!$past(wr_n, 3) || !$past(wr_n, 4)))
    else $error("power bit changed without write");
  chk_int_cleared: assert property (rd_start |-> ##[1:4] status_n)
    else $error("status not high after read");
  chk_oe_on_read: assert property ($rose(data_port_lines_oe) |-> !rd_n && !cs_n)
    else $error("data driven without read");
  chk_oe_release: assert property ($rose(rd_n) |-> ##[1:4] !data_port_lines_oe)
    else $error("data lines not released");
endmodule : acs_monitor
bind acs_sequencer acs_monitor acs_monitor_inst (.clk_sys(clk_sys), .reset(reset),
  .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_port_lines_oe(data_port_lines_oe),
  .status_n(status_n), .sample_hold(sample_hold), .code_take(code_take),
  .linear_off(linear_off));

// ===== verification/acs_host_model.sv
// host side model: converter clock and the shared data lines
// assumes the bench drives the strobes; the data lines have no pull
`timescale 1ns/1ps
module acs_host_model
  import acs_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // line drivers
  input wire logic host_en,
  input wire logic [DATA_W-1:0] host_data,
  input wire logic data_port_lines_oe,
  input wire logic [DATA_W-1:0] data_port_lines_out,
  // pins seen by the device
  output logic clkin,
  output logic [DATA_W-1:0] data_port_lines_in
);
  // ==========
  // clock and bus
  logic [2:0] div = 3'h0;
  logic [DATA_W-1:0] last = 10'h000;
  always_ff @(posedge clk_sys) div <= div + 3'h1;
  assign clkin = div[2];
  // released lines show the inverse of their last level
  always_ff @(posedge clk_sys) last <= data_port_lines_in;
  assign data_port_lines_in = data_port_lines_oe ? data_port_lines_out :
    host_en ? host_data : ~last;
endmodule : acs_host_model

// ===== verification/test_acs_sequencer.sv
// self-checking bench of the conversion sequencer
// assumes the host model paces clkin at 8 clk_sys cycles
`timescale 1ns/1ps
module test_acs_sequencer
  import acs_pkg::*;
;
  // ==========
  // signals and instances
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, host_en = 1'b0;
  logic [9:0] raw_code = 10'h000, host_data = 10'h000, din, dout;
  logic [9:0] code_a = 10'h000, code_b = 10'h000;
  logic clkin, oe, status_n, sample_hold, code_take, linear_off;
  integer err_count = 0, samples_checked = 0, seed = 32'h13d26ceb, k;
  acs_sequencer acs_sequencer_inst (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .clkin(clkin), .data_port_lines_in(din),
    .data_port_lines_out(dout), .data_port_lines_oe(oe), .status_n(status_n),
    .raw_code(raw_code), .sample_hold(sample_hold), .code_take(code_take),
    .linear_off(linear_off));
  acs_host_model acs_host_model_inst (.clk_sys(clk_sys), .host_en(host_en),
    .host_data(host_data), .data_port_lines_oe(oe), .data_port_lines_out(dout),
    .clkin(clkin), .data_port_lines_in(din));
  initial forever #12.5 clk_sys = ~clk_sys;
  // core code: first code until the first take, then the second one
  always @(posedge clk_sys) begin
    if (!sample_hold) raw_code <= code_a;
    else if (code_take) raw_code <= code_b;
  end
  // ==========
  // tasks
  task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task complete_run;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // bounded wait, n counts cycles since the strobe rose
  task wait_st(input logic v, inout integer n);
    while (status_n !== v && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_st
  // data held two cycles past the strobe rise
  task wr(input logic [9:0] w);
    @(posedge clk_sys);
    {cs_n, wr_n, host_en, host_data} <= {3'b001, w};
    repeat (4) @(posedge clk_sys);
    wr_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    {cs_n, host_en} <= 2'b10;
  endtask : wr
  task rd(input logic [9:0] exp);
    @(posedge clk_sys);
    {cs_n, rd_n} <= 2'b00;
    repeat (5) @(posedge clk_sys);
    chk("read_oe", 10'h001, {9'h000, oe});
    chk("read_data", exp, din);
    {cs_n, rd_n} <= 2'b11;
    repeat (6) @(posedge clk_sys);
  endtask : rd
  // one conversion: limits are 1.5/2.5, 19.5 and 33.5 clkin plus pin latency
  task run(input logic [9:0] w);
    integer n;
    code_a = 10'($random(seed));
    code_b = 10'($random(seed));
    wr(w);
    n = 2;
    if (!w[9]) wait_st(1'b0, n);
    if (!w[9]) chk("busy_fall", 10'h001, {9'h000, n >= 12 && n <= 26});
    wait_st(~w[9], n);
    chk("done_time", 10'h001, {9'h000, n <= (w[6] ? 274 : 162)});
    rd(code_a ^ 10'h200);
    rd((w[6] ? code_b : code_a) ^ 10'h200);
    chk("status_idle", 10'h001, {9'h000, status_n});
    repeat (40) @(posedge clk_sys);
  endtask : run
  // ==========
  // sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("reset_state", 10'h001, {8'h00, linear_off, status_n});
    for (k = 0; k < 4; k++) run({k[1], 2'h0, k[0], 6'h00} | (10'($random(seed)) & 10'h03f));
    wr(10'h300);
    repeat (200) @(posedge clk_sys);
    chk("power_down", 10'h005, {7'h00, linear_off, sample_hold, status_n});
    run(10'h000);
    chk("powered_up", 10'h000, {9'h000, linear_off});
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    complete_run;
  end
endmodule : test_acs_sequencer
